// [hdl/dbs_pkg.sv]
// Constants for the burst-of-four separate-I/O memory port.
// Assumes a single system clock sampling all pins.
package dbs_pkg;
    localparam int unsigned CLK_PERIOD_PS    = 8000;
    localparam int unsigned CAL_INTERVAL_NS  = 1024000;
    localparam int unsigned CAL_INTERVAL_CYC = (CAL_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned BURST_BEATS      = 4;
    localparam int unsigned LANE_BITS_BYTE   = 9;
    localparam int unsigned LANE_BITS_NIB    = 4;
    localparam int unsigned IMP_CODE_W       = 5;
    localparam logic [4:0]  IMP_CODE_RESET   = 5'h10;
    localparam int unsigned WFIFO_DEPTH      = 16;

    typedef enum logic [1:0] {
        DBS_CMD_NONE  = 2'b00,
        DBS_CMD_READ  = 2'b01,
        DBS_CMD_WRITE = 2'b10
    } dbs_cmd_t;
endpackage : dbs_pkg

// [hdl/dbs_fifo.sv]
// The write FIFO module dbs_fifo is kept in dbs_port.sv beside its only user.
// Assumes dbs_port.sv is read as well; this file holds no code.

// [hdl/dbs_port.sv]
// Device side of a DDR burst-of-four separate-I/O memory port.
// Assumes all pins, including the input and output clock pairs, are
// asynchronous to clk and much slower, so clk samples them to find edges.
`timescale 1ns/1ps
`default_nettype none
module dbs_port
    import dbs_pkg::*;
#(
    parameter int unsigned DATA_W   = 18,
    parameter int unsigned ADDR_W   = 8,
    parameter int unsigned CAL_CYC  = CAL_INTERVAL_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                in_clk,
    input  wire logic                in_clk_n,
    input  wire logic                out_clk,
    input  wire logic                out_clk_n,
    input  wire logic [ADDR_W-1:0]   burst_address,
    input  wire logic                read_sel_n,
    input  wire logic                write_sel_n,
    input  wire logic [DATA_W-1:0]   write_data,
    input  wire logic [DATA_W/((DATA_W == 8) ? LANE_BITS_NIB : LANE_BITS_BYTE)-1:0] lane_mask_n,
    input  wire logic                dll_off_n,
    input  wire logic                impedance_ref_pin,
    output logic [DATA_W-1:0]        read_data,
    output logic                     read_valid,
    output logic [IMP_CODE_W-1:0]    drive_code,
    output logic                     dll_enabled,
    output logic                     write_overflow
);
    // Lane geometry: nibbles for the 8-bit variant, nine-bit bytes otherwise
    localparam int unsigned LW = (DATA_W == 8) ? LANE_BITS_NIB : LANE_BITS_BYTE;
    localparam int unsigned NM = DATA_W / LW;
    localparam int unsigned BW = BURST_BEATS * DATA_W;
    localparam int unsigned FW = ADDR_W + BW + BURST_BEATS * NM;
    // Refuse widths the lane logic cannot serve
    if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_data_w
        $error("DATA_W must be 8, 9, 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    if (CAL_CYC < 2) begin : g_bad_cal_cyc
        $error("CAL_CYC too small");
    end
    if (BW != BURST_BEATS * NM * LW) begin : g_bad_lanes
        $error("Lanes do not tile the burst word");
    end

    // Two-stage synchronisers for every pin
    localparam int unsigned SW = 7 + ADDR_W + DATA_W + NM;
    logic [SW-1:0] pin_meta;
    logic [SW-1:0] pin_sync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {in_clk, in_clk_n, out_clk, out_clk_n, read_sel_n, write_sel_n,
                         dll_off_n, burst_address, write_data, lane_mask_n};
            pin_sync <= pin_meta;
        end
    end
    wire              k_s   = pin_sync[SW-1];
    wire              kn_s  = pin_sync[SW-2];
    wire              c_s   = pin_sync[SW-3];
    wire              cn_s  = pin_sync[SW-4];
    wire              r_n_s = pin_sync[SW-5];
    wire              w_n_s = pin_sync[SW-6];
    wire              doff_s = pin_sync[SW-7];
    wire [ADDR_W-1:0] a_s   = pin_sync[DATA_W+NM +: ADDR_W];
    wire [DATA_W-1:0] d_s   = pin_sync[NM +: DATA_W];
    wire [NM-1:0]     m_s   = pin_sync[NM-1:0];

    // Rises ignored until the synchronisers hold real pin levels
    logic [1:0] warm;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) warm <= 2'd0;
        else if (warm != 2'd3) warm <= warm + 2'd1;
    end
    wire live = warm == 2'd3;

    // Edge detection on sampled clocks
    logic k_d, kn_d, c_d, cn_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            k_d  <= 1'b0;
            kn_d <= 1'b0;
            c_d  <= 1'b0;
            cn_d <= 1'b0;
        end else begin
            k_d  <= k_s;
            kn_d <= kn_s;
            c_d  <= c_s;
            cn_d <= cn_s;
        end
    end
    wire k_rise  = live && k_s && !k_d;
    wire kn_rise = live && kn_s && !kn_d;
    wire c_rise  = live && c_s && !c_d;
    wire cn_rise = live && cn_s && !cn_d;
    wire k_mode  = c_s && cn_s && c_d && cn_d;
    wire pos_fire = k_mode ? k_rise : c_rise;
    wire neg_fire = k_mode ? kn_rise : cn_rise;

    // Command decode
    dbs_cmd_t last_cmd;
    wire rd_go = k_rise && !r_n_s && (last_cmd != DBS_CMD_READ);
    wire wr_go = k_rise && r_n_s && !w_n_s && (last_cmd != DBS_CMD_WRITE);
    logic wr_busy;
    logic rd_busy;
    wire      wr_take = wr_go && !wr_busy;
    dbs_cmd_t next_last_cmd;
    assign next_last_cmd = rd_go ? DBS_CMD_READ : wr_take ? DBS_CMD_WRITE : last_cmd;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) last_cmd <= DBS_CMD_NONE;
        else last_cmd <= next_last_cmd;
    end

    // Write beat gathering
    logic [ADDR_W-1:0]         wr_addr;
    logic [2:0]                wr_beat;
    logic [BW-1:0]             wr_data;
    logic [BURST_BEATS*NM-1:0] wr_mask_n;
    logic                      wr_push;
    logic                      fifo_in_ready;
    wire beat_edge = wr_busy && (wr_beat[0] ? kn_rise : k_rise) && !(wr_beat == 3'd0 && wr_go);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_busy   <= 1'b0;
            wr_beat   <= 3'd0;
            wr_addr   <= '0;
            wr_data   <= '0;
            wr_mask_n <= '1;
            wr_push   <= 1'b0;
        end else begin
            wr_push <= 1'b0;
            if (wr_take) begin
                wr_busy <= 1'b1;
                wr_beat <= 3'd0;
                wr_addr <= a_s;
            end else if (beat_edge) begin
                wr_data[wr_beat[1:0]*DATA_W +: DATA_W] <= d_s;
                wr_mask_n[wr_beat[1:0]*NM +: NM] <= m_s;
                wr_beat <= wr_beat + 3'd1;
                if (wr_beat == 3'd3) begin
                    wr_busy <= 1'b0;
                    wr_push <= 1'b1;
                end
            end
        end
    end

    // Gathered bursts queue ahead of the array
    logic          q_valid;
    logic          q_ready;
    logic [FW-1:0] q_data;
    dbs_fifo #(.WIDTH(FW), .DEPTH(WFIFO_DEPTH)) u_wfifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (wr_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({wr_addr, wr_mask_n, wr_data}),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) write_overflow <= 1'b0;
        else if (wr_push && !fifo_in_ready) write_overflow <= 1'b1;
    end

    // Array: one wide word per burst address
    logic [BW-1:0] mem [1 << ADDR_W];
    wire [ADDR_W-1:0] q_addr = q_data[FW-1 -: ADDR_W];
    wire [BURST_BEATS*NM-1:0] q_mask_n = q_data[BW +: BURST_BEATS*NM];
    // Read launch stalls drain so reads see a stable word
    assign q_ready = !rd_go;
    // Masked lanes keep the stored contents
    wire [BW-1:0] old_word = mem[q_addr];
    wire [BW-1:0] merge_word;
    genvar g;
    generate
        for (g = 0; g < BURST_BEATS * NM; g++) begin : g_lane
            assign merge_word[g*LW +: LW] = q_mask_n[g] ? old_word[g*LW +: LW] : q_data[g*LW +: LW];
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (q_valid && q_ready) mem[q_addr] <= merge_word;
    end

    // Read path: whole burst fetched at once
    logic [BW-1:0] rd_word;
    logic [2:0]    rd_beat;
    logic          rd_armed;
    // Beats alternate neg, pos, neg, pos after the arming rise
    wire           rd_fire = rd_beat[0] ? pos_fire : neg_fire;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word    <= '0;
            rd_busy    <= 1'b0;
            rd_armed   <= 1'b0;
            rd_beat    <= 3'd0;
            read_data  <= '0;
            read_valid <= 1'b0;
        end else begin
            if (rd_go) begin
                rd_word  <= mem[a_s];
                rd_busy  <= 1'b1;
                rd_armed <= 1'b0;
                rd_beat  <= 3'd0;
            end else if (rd_busy && !rd_armed && k_rise) begin
                rd_armed <= 1'b1;
            end else if (rd_busy && rd_armed && rd_fire) begin
                read_data  <= rd_word[rd_beat[1:0]*DATA_W +: DATA_W];
                read_valid <= 1'b1;
                rd_beat    <= rd_beat + 3'd1;
                if (rd_beat == 3'd3) rd_busy <= 1'b0;
            end else if (!rd_busy && (pos_fire || neg_fire)) begin
                read_valid <= 1'b0;
            end
        end
    end

    // Impedance calibration
    localparam int unsigned CW = $clog2(CAL_CYC);
    logic [CW-1:0] cal_cnt;
    logic          ref_meta, ref_sync;
    wire cal_tick = cal_cnt == CW'(CAL_CYC - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_cnt    <= '0;
            ref_meta   <= 1'b0;
            ref_sync   <= 1'b0;
            drive_code <= IMP_CODE_RESET;
        end else begin
            ref_meta <= impedance_ref_pin;
            ref_sync <= ref_meta;
            cal_cnt  <= cal_tick ? '0 : cal_cnt + 1'b1;
            if (cal_tick) begin
                if (ref_sync && drive_code != '1) drive_code <= drive_code + 1'b1;
                else if (!ref_sync && drive_code != '0) drive_code <= drive_code - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) dll_enabled <= 1'b0;
        else dll_enabled <= doff_s;
    end
endmodule : dbs_port

// Valid/ready FIFO holding gathered write bursts
module dbs_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers carry one extra bit to tell full from empty
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire [AW:0]       fill = wr_ptr - rd_ptr;
    assign in_ready  = fill != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule : dbs_fifo
`default_nettype wire

// [bench/dbs_port_properties.sv]
// Pin-level assertions for dbs_port.
// Assumes it is bound onto every dbs_port instance.
`timescale 1ns/1ps
`default_nettype none
module dbs_port_chk
    import dbs_pkg::*;
#(
    parameter int unsigned DATA_W  = 18,
    parameter int unsigned CAL_CYC = 8
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  in_clk,
    input wire logic                  in_clk_n,
    input wire logic                  out_clk,
    input wire logic                  out_clk_n,
    input wire logic                  read_sel_n,
    input wire logic                  dll_off_n,
    input wire logic [DATA_W-1:0]     read_data,
    input wire logic                  read_valid,
    input wire logic [IMP_CODE_W-1:0] drive_code,
    input wire logic                  dll_enabled,
    input wire logic                  write_overflow
);
    logic [3:0]  clk_q;
    logic [7:0]  fire_age;
    logic [7:0]  rd_age;
    logic [31:0] gap;
    wire         fire = |({in_clk, in_clk_n, out_clk, out_clk_n} & ~clk_q);
    // Ages since a clock pin rose, since a read select, since a code change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 4'hf;
            fire_age <= 8'hff;
            rd_age <= 8'hff;
            gap <= 32'(CAL_CYC);
        end else begin
            clk_q <= {in_clk, in_clk_n, out_clk, out_clk_n};
            fire_age <= fire ? 8'h00 : fire_age + {7'h0, fire_age != 8'hff};
            rd_age <= (in_clk && !clk_q[3] && !read_sel_n) ? 8'h00 : rd_age + {7'h0, rd_age != 8'hff};
            gap <= $changed(drive_code) ? 32'h0 : gap + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_CODE_STEP: assert property ($changed(drive_code) |->
        drive_code == $past(drive_code) + 5'h01 || drive_code == $past(drive_code) - 5'h01)
        else $error("drive code jumped");
    AST_CODE_RATE: assert property ($changed(drive_code) |-> gap >= CAL_CYC - 1)
        else $error("drive code changed too soon");
    AST_DLL_ON: assert property (dll_off_n [*6] |-> dll_enabled)
        else $error("dll not enabled");
    AST_DLL_OFF: assert property ((!dll_off_n) [*6] |-> !dll_enabled)
        else $error("dll not disabled");
    AST_READ_CAUSE: assert property ($rose(read_valid) |-> rd_age < 8'h28)
        else $error("read data without read command");
    AST_DATA_HOLD: assert property ($changed(read_data) |-> read_valid)
        else $error("read data changed while idle");
    AST_DATA_FIRE: assert property ($changed(read_data) |-> fire_age <= 8'h05)
        else $error("read beat not tied to a clock edge");
    AST_OVF_STICKY: assert property (write_overflow |=> write_overflow)
        else $error("overflow flag dropped");
    COV_READ: cover property ($rose(read_valid));
    COV_STEP: cover property ($changed(drive_code));
    COV_DLL: cover property ($fell(dll_enabled));
endmodule : dbs_port_chk
bind dbs_port dbs_port_chk #(.DATA_W(DATA_W), .CAL_CYC(CAL_CYC)) chk (
    .clk(clk), .rst_n(rst_n), .in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .read_sel_n(read_sel_n), .dll_off_n(dll_off_n), .read_data(read_data),
    .read_valid(read_valid), .drive_code(drive_code), .dll_enabled(dll_enabled),
    .write_overflow(write_overflow));
`default_nettype wire

// [bench/dbs_host.sv]
// Host controller model driving the port's clock pairs, commands and data.
// Assumes clk is the bench clock; pins change only after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module dbs_host #(
    parameter int DW = 18,
    parameter int NM = 2
) (
    input  wire logic          clk,
    input  wire logic [DW-1:0] read_data,
    output logic               in_clk,
    output logic               in_clk_n,
    output logic               out_clk,
    output logic               out_clk_n,
    output logic [7:0]         burst_address,
    output logic               read_sel_n,
    output logic               write_sel_n,
    output logic [DW-1:0]      write_data,
    output logic [NM-1:0]      lane_mask_n
);
    bit oc_mode;
    initial begin
        oc_mode = 1'b0;
        {in_clk, in_clk_n, out_clk, out_clk_n} = 4'h3;
        {read_sel_n, write_sel_n, burst_address, write_data, lane_mask_n} = '1;
    end
    // pins settle, clock rises, delayed output clock
    task automatic half(input bit k, input bit rs, input bit ws, input logic [7:0] a,
                        input logic [DW-1:0] d, input logic [NM-1:0] m, output logic [DW-1:0] q);
        @(posedge clk);
        {in_clk, in_clk_n, out_clk, out_clk_n} <= {2'b00, {2{!oc_mode}}};
        {read_sel_n, write_sel_n, burst_address, write_data, lane_mask_n} <= {rs, ws, a, d, m};
        repeat (2) @(posedge clk);
        {in_clk, in_clk_n} <= {k, !k};
        @(posedge clk);
        if (oc_mode) begin
            {out_clk, out_clk_n} <= {k, !k};
        end
        repeat (4) @(posedge clk);
        q = read_data;
    endtask : half
    // command, then beats with masks on k, kn, k, kn
    task automatic op(input bit rs, input bit ws, input logic [7:0] a, input logic [4*DW-1:0] d,
                      input logic [4*NM-1:0] m, output logic [4*DW-1:0] q);
        logic [DW-1:0] t;
        q = '0;
        half(1'b1, rs, ws, a, DW'($urandom), NM'($urandom), t);
        for (int e = 1; e < 8; e++) begin
            if (e >= 2 && e <= 5)
                half(!e[0], !e[0], !e[0], ~a, d[(e-2)*DW +: DW], m[(e-2)*NM +: NM], t);
            else
                half(!e[0], !e[0], !e[0], ~a, DW'($urandom), NM'($urandom), t);
            if (e >= 3 && e <= 6)
                q[(e-3)*DW +: DW] = t;
        end
    endtask : op
endmodule : dbs_host
`default_nettype wire

// [bench/dbs_port_tb.sv]
// Self-checking bench for dbs_port with a memory model.
// Assumes dbs_host drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module dbs_port_tb;
    import dbs_pkg::*;
    localparam int DW = 18;
    localparam int NM = 2;
    localparam int BW = 4 * DW;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          dll_off_n = 1'b1;
    logic          impedance_ref_pin = 1'b0;
    wire           in_clk, in_clk_n, out_clk, out_clk_n, read_sel_n, write_sel_n;
    wire           read_valid, dll_enabled, write_overflow;
    wire [7:0]     burst_address;
    wire [DW-1:0]  write_data, read_data;
    wire [NM-1:0]  lane_mask_n;
    wire [4:0]     drive_code;
    int            n_errors = 0;
    int            checks = 0;
    int            cyc = 0;
    int            vhits = 0;
    logic [BW-1:0] mem [int];
    always #4 clk = ~clk;
    dbs_host #(.DW(DW), .NM(NM)) host (.clk(clk), .read_data(read_data), .in_clk(in_clk),
        .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n), .burst_address(burst_address),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .write_data(write_data),
        .lane_mask_n(lane_mask_n));
    dbs_port #(.DATA_W(DW), .ADDR_W(8), .CAL_CYC(8)) dut (.clk(clk), .rst_n(rst_n), .in_clk(in_clk),
        .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n), .burst_address(burst_address),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .write_data(write_data),
        .lane_mask_n(lane_mask_n), .dll_off_n(dll_off_n), .impedance_ref_pin(impedance_ref_pin),
        .read_data(read_data), .read_valid(read_valid), .drive_code(drive_code),
        .dll_enabled(dll_enabled), .write_overflow(write_overflow));
    task automatic test_done();
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (read_valid === 1'b1)
            vhits++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [BW-1:0] seen, input logic [BW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [BW-1:0] rnd();
        logic [95:0] r;
        r = {$urandom, $urandom, $urandom};
        return r[BW-1:0];
    endfunction : rnd
    task automatic wr(input logic [7:0] a, input logic [BW-1:0] d, input logic [4*NM-1:0] m, input bit ok);
        logic [BW-1:0] q;
        host.op(1'b1, 1'b0, a, d, m, q);
        for (int i = 0; i < 4 * NM; i++)
            if (ok && !m[i])
                mem[a][i*9 +: 9] = d[i*9 +: 9];
    endtask : wr
    task automatic cmd(input bit rs, input logic [7:0] a, input bit ok);
        logic [BW-1:0] q;
        int v0;
        v0 = vhits;
        host.op(rs, 1'b1, a, '0, '0, q);
        if (ok)
            check("read burst", q, mem[a]);
        else
            check("idle valid", BW'(vhits - v0), '0);
    endtask : cmd
    initial begin
        logic [7:0] a;
        void'($urandom(11));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("drive code", BW'(drive_code), BW'(IMP_CODE_RESET));
        for (int i = 0; i < 4; i++) begin
            wr(8'(i), rnd(), 8'h00, 1'b1);
            cmd(1'b0, 8'(i), 1'b1);
        end
        impedance_ref_pin <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            host.oc_mode = i[0];
            a = 8'($urandom_range(3));
            wr(a, rnd(), 8'($urandom), 1'b1);
            cmd(1'b0, a, 1'b1);
        end
        check("code up", BW'(drive_code), BW'(5'h1f));
        host.oc_mode = 1'b0;
        wr(8'h01, rnd(), 8'h00, 1'b1);
        wr(8'h01, rnd(), 8'h00, 1'b0);
        cmd(1'b1, 8'h02, 1'b0);
        cmd(1'b0, 8'h01, 1'b1);
        cmd(1'b0, 8'h01, 1'b0);
        impedance_ref_pin <= 1'b0;
        dll_off_n <= 1'b0;
        repeat (300) @(posedge clk);
        check("code down", BW'(drive_code), '0);
        check("dll off", BW'(dll_enabled), '0);
        dll_off_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("dll on", BW'(dll_enabled), BW'(1));
        check("overflow", BW'(write_overflow), '0);
        test_done();
    end
endmodule : dbs_port_tb
`default_nettype wire
